// >>> hdl/spp_top.sv
// sector password protection: guard bytes, passwords, access decisions
// assumes rf and serial request ports come from on-chip logic on CLK
`timescale 1ns/1ns
`include "spp_defs.svh"
module spp_top #(
  parameter logic [15:0] NV_WR_CYC = `SPP_NVWR_CYC
) (
  input  wire logic                  CLK,        // 250 MHz clock
  input  wire logic                  RESET_N,    // async reset, low
  input  wire spp_pkg::spp_rf_req_t  RF_REQ,     // rf command
  output logic                       RF_READY,   // rf command taken
  output spp_pkg::spp_rf_rsp_t       RF_RSP,     // rf answer
  output logic                       MEM_GO,     // start memory op
  output logic                       MEM_WE,     // memory op is write
  output logic [12:0]                MEM_ADDR,   // serial byte address
  input  wire spp_pkg::spp_ser_req_t SER_REQ,    // serial guard access
  output logic                       SER_ACK,    // serial answer
  output logic [7:0]                 SER_RDATA   // serial read byte
);
  import spp_pkg::*;

  spp_state_t s_q;
  spp_state_t s_d;

  // access decision of one guard byte, returns {read, write}
  function automatic logic [1:0] spp_access(input logic [7:0] g,
                                            input logic [1:0] pres);
    logic have;
    have = (g[4:3] != 2'b00) && (g[4:3] == pres);
    spp_access = 2'b11;
    if (g[`SPP_LOCK_POS]) begin
      unique case (g[2:1])
        2'b00: spp_access = {1'b1, have};
        2'b01: spp_access = 2'b11;
        2'b10: spp_access = {have, have};
        2'b11: spp_access = {have, 1'b0};
      endcase
    end
  endfunction

  logic [5:0]  acc_sec;
  logic [5:0]  lock_sec;
  logic [7:0]  acc_g;
  logic [1:0]  acc;
  logic        pidx_ok;
  logic [1:0]  pidx_in;

  // sector of an rf block is its top six bits
  assign acc_sec  = RF_REQ.addr[10:5];
  assign lock_sec = RF_REQ.addr[5:0];
  assign acc_g    = s_q.guard[acc_sec];
  assign acc      = spp_access(acc_g, s_q.pres);
  assign pidx_in  = RF_REQ.addr[1:0];
  assign pidx_ok  = (RF_REQ.addr[10:2] == 9'h000) && (pidx_in != 2'b00);
  assign RF_READY = (s_q.st == SPP_ST_IDLE);

  // next state: rf commands, nv write timer, serial guard access
  always_comb begin
    s_d         = s_q;
    s_d.rsp.done = 1'b0;
    s_d.mem_go  = 1'b0;
    s_d.ser_ack = 1'b0;
    unique case (s_q.st)
      SPP_ST_IDLE: begin
        if (RF_REQ.vld) begin
          s_d.rsp.done      = 1'b1;
          s_d.rsp.err       = 1'b0;
          s_d.rsp.gbyte_vld = 1'b0;
          s_d.rsp.gbyte     = acc_g;
          unique case (RF_REQ.cmd)
            SPP_CMD_READ: begin
              if (acc[1]) begin
                s_d.mem_go   = 1'b1;
                s_d.mem_we   = 1'b0;
                s_d.mem_addr = {RF_REQ.addr, 2'b00};
                s_d.rsp.gbyte_vld = RF_REQ.opt;
              end else begin
                s_d.rsp.err = 1'b1;
              end
            end
            SPP_CMD_WRITE: begin
              if (acc[0]) begin
                s_d.mem_go   = 1'b1;
                s_d.mem_we   = 1'b1;
                s_d.mem_addr = {RF_REQ.addr, 2'b00};
              end else begin
                s_d.rsp.err = 1'b1;
              end
            end
            SPP_CMD_PRESENT: begin
              if (pidx_ok) begin
                // a wrong value drops every right, not only its own
                s_d.pres = (RF_REQ.data == s_q.pwd[pidx_in - 2'd1]) ? pidx_in : 2'b00;
              end else begin
                s_d.rsp.err = 1'b1;
              end
            end
            SPP_CMD_PWD_WR: begin
              if (pidx_ok && (s_q.pres == pidx_in)) begin
                s_d.rsp.done = 1'b0; // answered when the nv cycle ends
                s_d.st   = SPP_ST_NVWR;
                s_d.cnt  = 16'h0000;
                s_d.pidx = pidx_in;
                s_d.pval = RF_REQ.data;
              end else begin
                s_d.rsp.err = 1'b1;
              end
            end
            SPP_CMD_LOCK: begin
              if (s_q.guard[lock_sec][`SPP_LOCK_POS]) begin
                s_d.rsp.err = 1'b1;
              end else begin
                // takes effect on the next cycle's decisions
                s_d.guard[lock_sec] = {3'b000, RF_REQ.data[4:1], 1'b1};
              end
            end
            default: s_d.rsp.err = 1'b1;
          endcase
        end
      end
      SPP_ST_NVWR: begin
        // old password stays in use until the cycle ends
        s_d.cnt = s_q.cnt + 16'h0001;
        if (s_q.cnt == NV_WR_CYC - 16'h0001) begin
          s_d.pwd[s_q.pidx - 2'd1] = s_q.pval;
          s_d.st       = SPP_ST_IDLE;
          s_d.rsp.done = 1'b1;
          s_d.rsp.err  = 1'b0;
          s_d.rsp.gbyte_vld = 1'b0;
        end
      end
    endcase
    // serial side wins a same-cycle clash, it is the owner's path
    if (SER_REQ.vld) begin
      s_d.ser_ack = 1'b1;
      s_d.ser_rd  = 8'h00;
      if (SER_REQ.area && (SER_REQ.addr[12:6] == 7'h00)) begin
        if (SER_REQ.wr) begin
          s_d.guard[SER_REQ.addr[5:0]] = {3'b000, SER_REQ.wdata[4:0]};
        end else begin
          s_d.ser_rd = s_q.guard[SER_REQ.addr[5:0]];
        end
      end
    end
  end

  // state register; guard and password reset to delivery values
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      s_q       <= '0;
      s_q.st    <= SPP_ST_IDLE;
      s_q.guard <= {64{`SPP_GUARD_RST}};
      s_q.pwd   <= {3{`SPP_PWD_RST}};
    end else begin
      s_q <= s_d;
    end
  end

  assign RF_RSP    = s_q.rsp;
  assign MEM_GO    = s_q.mem_go;
  assign MEM_WE    = s_q.mem_we;
  assign MEM_ADDR  = s_q.mem_addr;
  assign SER_ACK   = s_q.ser_ack;
  assign SER_RDATA = s_q.ser_rd;

  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  logic idle_req;
  logic ser_gw;
  assign idle_req = RF_REQ.vld && RF_READY;
  assign ser_gw   = SER_REQ.vld && SER_REQ.wr && SER_REQ.area && (SER_REQ.addr[12:6] == 7'h00);

  sequence seq_pwd_start;
    idle_req && (RF_REQ.cmd == SPP_CMD_PWD_WR) && pidx_ok && (s_q.pres == pidx_in);
  endsequence
  sequence seq_pwd_busy;
    (!RF_READY && !RF_RSP.done) [*2];
  endsequence

  chk_lock_error: assert property (
    idle_req && (RF_REQ.cmd == SPP_CMD_LOCK) && s_q.guard[lock_sec][0] && !SER_REQ.vld
    |=> RF_RSP.done && RF_RSP.err)
    else $error("lock of locked sector not refused");

  chk_lock_sets: assert property (
    idle_req && (RF_REQ.cmd == SPP_CMD_LOCK) && !s_q.guard[lock_sec][0] && !SER_REQ.vld
    |=> s_q.guard[$past(lock_sec)] == {3'b000, $past(RF_REQ.data[4:1]), 1'b1})
    else $error("lock did not store guard byte");

  chk_pwd_gate: assert property (
    idle_req && (RF_REQ.cmd == SPP_CMD_PWD_WR) && (s_q.pres != pidx_in)
    |=> RF_RSP.done && RF_RSP.err && RF_READY)
    else $error("password write without presentation");

  chk_pwd_cycle: assert property (
    seq_pwd_start |=> seq_pwd_busy)
    else $error("password write answered too early");

  chk_pwd_apply: assert property (
    (s_q.st == SPP_ST_NVWR) && (s_q.cnt == NV_WR_CYC - 16'h0001)
    |=> RF_READY && RF_RSP.done && (s_q.pwd[$past(s_q.pidx) - 2'd1] == $past(s_q.pval)))
    else $error("password not applied at end of write");

  chk_wrong_clears: assert property (
    idle_req && (RF_REQ.cmd == SPP_CMD_PRESENT) && pidx_ok && (RF_REQ.data != s_q.pwd[pidx_in - 2'd1])
    |=> s_q.pres == 2'b00)
    else $error("wrong password kept rights");

  chk_unlocked_free: assert property (
    idle_req && !acc_g[0] && ((RF_REQ.cmd == SPP_CMD_READ) || (RF_REQ.cmd == SPP_CMD_WRITE))
    |=> MEM_GO && !RF_RSP.err)
    else $error("unlocked sector access refused");

  chk_code11_nowr: assert property (
    idle_req && (RF_REQ.cmd == SPP_CMD_WRITE) && acc_g[0] && (acc_g[2:1] == 2'b11)
    |=> RF_RSP.err && !MEM_GO)
    else $error("write allowed on code 11 sector");

  chk_addr_map: assert property (
    MEM_GO |-> (MEM_ADDR == {$past(RF_REQ.addr), 2'b00}))
    else $error("block to byte address mismatch");

  chk_opt_status: assert property (
    idle_req && (RF_REQ.cmd == SPP_CMD_READ) && acc[1] && RF_REQ.opt
    |=> RF_RSP.gbyte_vld && (RF_RSP.gbyte == $past(acc_g)))
    else $error("guard byte not returned");

  chk_ser_write: assert property (
    ser_gw |=> (s_q.guard[$past(SER_REQ.addr[5:0])] == {3'b000, $past(SER_REQ.wdata[4:0])}) && SER_ACK)
    else $error("serial guard write lost");

  chk_rsvd_zero: assert property (
    RF_RSP.gbyte_vld |-> (RF_RSP.gbyte[7:5] == 3'b000))
    else $error("reserved guard bits set");

endmodule // spp_top

// >>> inc/spp_defs.svh
// constants of the sector password protection block
// assumes a single CLK domain; included by spp_top
`ifndef SPP_DEFS_SVH
`define SPP_DEFS_SVH
`define SPP_SECTORS      64
`define SPP_BLK_PER_SEC  32
`define SPP_LAST_BLK     11'h7FF
`define SPP_LAST_BYTE    13'h1FFC
`define SPP_LOCK_POS     0
`define SPP_CODE_POS     1
`define SPP_LINK_POS     3
`define SPP_GUARD_RST    8'h00
`define SPP_PWD_RST      32'h0000_0000
`define SPP_NVWR_CYC     16'h03E8
`endif

// >>> inc/spp_pkg.sv
// types of the sector password protection block
// assumes spp_defs.svh on the include path
package spp_pkg;
  typedef enum logic [2:0] {
    SPP_CMD_READ    = 3'b000,
    SPP_CMD_WRITE   = 3'b001,
    SPP_CMD_PRESENT = 3'b010,
    SPP_CMD_PWD_WR  = 3'b011,
    SPP_CMD_LOCK    = 3'b100
  } spp_cmd_t;
  typedef enum logic [0:0] {
    SPP_ST_IDLE = 1'b0,
    SPP_ST_NVWR = 1'b1
  } spp_st_t;
  typedef struct packed {
    logic        vld;
    spp_cmd_t    cmd;
    logic [10:0] addr;
    logic        opt;
    logic [31:0] data;
  } spp_rf_req_t;
  typedef struct packed {
    logic       done;
    logic       err;
    logic       gbyte_vld;
    logic [7:0] gbyte;
  } spp_rf_rsp_t;
  typedef struct packed {
    logic        vld;
    logic        wr;
    logic        area;
    logic [12:0] addr;
    logic [7:0]  wdata;
  } spp_ser_req_t;
  typedef struct packed {
    spp_st_t          st;
    logic [15:0]      cnt;
    logic [1:0]       pres;
    logic [1:0]       pidx;
    logic [31:0]      pval;
    logic [2:0][31:0] pwd;
    logic [63:0][7:0] guard;
    spp_rf_rsp_t      rsp;
    logic             mem_go;
    logic             mem_we;
    logic [12:0]      mem_addr;
    logic             ser_ack;
    logic [7:0]       ser_rd;
  } spp_state_t;
endpackage

// >>> testbench/spp_host_bfm.sv
// rf reader and serial host model driving the guard block
// assumes requests change at the falling edge of clk
`timescale 1ns/1ns
module spp_host_bfm (
  input  wire logic                 clk,      // design clock
  input  wire logic                 rf_ready, // rf command taken
  input  wire spp_pkg::spp_rf_rsp_t rf_rsp,   // rf answer
  input  wire logic                 mem_go,   // memory start
  output spp_pkg::spp_rf_req_t      rf_req,   // rf command
  output spp_pkg::spp_ser_req_t     ser_req   // serial access
);
  import spp_pkg::*;
  int   tmo = 0;
  logic go;
  // idle values at time zero
  initial begin
    rf_req  = '0;
    ser_req = '0;
  end
  // hold the command until taken; released data is inverted so it never looks valid
  task automatic rf(input spp_cmd_t c, input logic [10:0] a, input logic o, input logic [31:0] d);
    int n;
    @(negedge clk);
    rf_req = '{1'b1, c, a, o, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rf_ready !== 1'b1 && n < 50);
    @(negedge clk);
    rf_req.vld  = 1'b0;
    rf_req.data = ~d;
    while (rf_rsp.done !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    if (n >= 100) tmo++;
    go = mem_go;
  endtask
  // one serial byte access, answer expected one cycle later
  task automatic ser(input logic w, input logic ar, input logic [12:0] a, input logic [7:0] d);
    @(negedge clk);
    ser_req = '{1'b1, w, ar, a, d};
    @(negedge clk);
    ser_req.vld   = 1'b0;
    ser_req.wdata = ~d;
  endtask
endmodule // spp_host_bfm

// >>> testbench/test_sector_password_protection.sv
// self-checking bench of the guard block against an integer model
// assumes spp_pkg compiled and spp_defs.svh on the include path
`timescale 1ns/1ns
module test_sector_password_protection;
  import spp_pkg::*;
  logic          clk = 0;
  logic          reset_n = 0;
  spp_rf_req_t   rf_req;
  spp_rf_rsp_t   rf_rsp;
  spp_ser_req_t  ser_req;
  logic          rf_ready, mem_go, mem_we, ser_ack;
  logic [12:0]   mem_addr;
  logic [7:0]    ser_rdata;
  int            error_cnt = 0, compares = 0, pres = 0;
  int            gb[64], pw[3];
  always #2 clk = ~clk;
  // short nv write keeps the run brief
  spp_top #(.NV_WR_CYC(16'h0004)) dut (.CLK(clk), .RESET_N(reset_n), .RF_REQ(rf_req), .RF_READY(rf_ready),
    .RF_RSP(rf_rsp), .MEM_GO(mem_go), .MEM_WE(mem_we), .MEM_ADDR(mem_addr), .SER_REQ(ser_req),
    .SER_ACK(ser_ack), .SER_RDATA(ser_rdata));
  spp_host_bfm bfm (.clk(clk), .rf_ready(rf_ready), .rf_rsp(rf_rsp), .mem_go(mem_go), .rf_req(rf_req),
    .ser_req(ser_req));
  task automatic print_verdict();
    $display("compares %0d, error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %0h seen %0h", nm, e, g);
    end
  endtask
  // access table: password counts only when the sector's link matches the record
  function automatic bit acc(int s, bit w);
    int lk = (gb[s] >> 3) & 3;
    int cd = (gb[s] >> 1) & 3;
    bit p  = lk != 0 && lk == pres;
    if ((gb[s] & 1) == 0) return 1;
    case (cd)
      0: return w ? p : 1'b1;
      1: return 1;
      2: return p;
      default: return w ? 1'b0 : p;
    endcase
  endfunction
  task automatic rf_op(input spp_cmd_t c, input int a, input bit o = 0, input int d = 0);
    int s = (a >> 5) & 63;
    bit ok = 0;
    bit ix = a >= 1 && a <= 3;
    bfm.rf(c, a[10:0], o, d[31:0]);
    if (bfm.tmo != 0) begin
      error_cnt++;
      print_verdict();
    end
    case (c)
      SPP_CMD_READ, SPP_CMD_WRITE: ok = acc(s, c == SPP_CMD_WRITE);
      SPP_CMD_PRESENT: begin
        ok = ix;
        if (ix) pres = (pw[a-1] == d) ? a : 0;
      end
      SPP_CMD_PWD_WR: begin
        ok = ix && pres == a;
        if (ok) pw[a-1] = d;
      end
      SPP_CMD_LOCK: begin
        ok = (gb[a & 63] & 1) == 0;
        if (ok) gb[a & 63] = (d & 'h1E) | 1;
      end
      default: ok = 0;
    endcase
    chk("err", !ok, rf_rsp.err);
    if (c == SPP_CMD_READ || c == SPP_CMD_WRITE) begin
      chk("mem_go", ok, bfm.go);
      if (ok) chk("mem_we", c == SPP_CMD_WRITE, mem_we);
      if (ok) chk("mem_addr", a * 4, mem_addr);
      if (ok && o && c == SPP_CMD_READ) chk("gbyte", gb[s] | 'h100, {rf_rsp.gbyte_vld, rf_rsp.gbyte});
    end
  endtask
  task automatic ser_op(input bit w, input bit ar, input int a, input int d = 0);
    int e = (ar && a < 64) ? gb[a] : 0;
    bfm.ser(w, ar, a[12:0], d[7:0]);
    if (w && ar && a < 64) gb[a] = d & 'h1F;
    chk("ser_ack", 1, ser_ack);
    if (!w) chk("ser_rdata", e, ser_rdata);
  endtask
  initial begin
    void'($urandom(68));
    foreach (gb[i]) gb[i] = 0;
    foreach (pw[i]) pw[i] = 0;
    repeat (20) @(negedge clk);
    reset_n = 1;
    for (int i = 0; i < 64; i += 9) ser_op(0, 1, i);
    ser_op(0, 0, 5);
    rf_op(SPP_CMD_READ, 2047, 1);
    rf_op(SPP_CMD_WRITE, 2016);
    rf_op(spp_cmd_t'(3'h7), 0);
    // sectors 1..4 on password 1, 5..8 on password 2, every code
    for (int i = 0; i < 8; i++) rf_op(SPP_CMD_LOCK, i + 1, 0, ((i / 4 + 1) << 3) | ((i % 4) << 1));
    rf_op(SPP_CMD_LOCK, 3, 0, 0);
    for (int k = 0; k < 3; k++) begin
      if (k == 1) rf_op(SPP_CMD_PRESENT, 1, 0, 0);
      if (k == 2) rf_op(SPP_CMD_PRESENT, 1, 0, 7);
      for (int i = 1; i < 9; i++) begin
        rf_op(SPP_CMD_READ, i * 32 + 5, 1);
        rf_op(SPP_CMD_WRITE, i * 32 + 5);
      end
    end
    rf_op(SPP_CMD_PWD_WR, 2, 0, 'h5A5A);
    rf_op(SPP_CMD_PRESENT, 2, 0, 0);
    rf_op(SPP_CMD_PWD_WR, 2, 0, 'h5A5A);
    rf_op(SPP_CMD_PRESENT, 2, 0, 'h5A5A);
    rf_op(SPP_CMD_WRITE, 7 * 32);
    rf_op(SPP_CMD_PRESENT, 0);
    ser_op(1, 1, 3, 'hFF);
    ser_op(0, 1, 3);
    ser_op(1, 1, 4, 0);
    rf_op(SPP_CMD_WRITE, 4 * 32 + 31);
    ser_op(1, 0, 4, 'h0F);
    ser_op(0, 1, 4);
    // random mix of accesses, guard rewrites and presentations
    repeat (300) begin
      int r;
      int j;
      // fresh draws every pass; a static initialiser would run only once
      r = $urandom;
      j = 1 + $urandom % 3;
      if (r[3:2] == 0) ser_op(r[4], r[5], $urandom % 80, $urandom);
      else rf_op(spp_cmd_t'(r[0]), $urandom % 2048, r[1]);
      if (r[9:6] == 0) rf_op(SPP_CMD_PRESENT, j, 0, r[10] ? pw[j-1] : r);
    end
    print_verdict();
  end
endmodule // test_sector_password_protection
